// ---- hdl/rcdp_regs.svh ----
// named constants of the controller data port
// assumes inclusion by bare name from every file that needs a figure
`ifndef RCDP_REGS_SVH
`define RCDP_REGS_SVH

`define RCDP_BYTE_W 8
`define RCDP_NIB_W 4
`define RCDP_BUF_DEPTH 2
`define RCDP_PIN_SYNC_W 16
`define RCDP_BUS_RST 8'h00
`define RCDP_NIB_RST 4'h0
`define RCDP_OE_OFF 1'b1
`define RCDP_FLAG_IDLE 1'b1
`define RCDP_WD_RST 1'b0

`endif

// ---- hdl/rcdp_pkg.sv ----
// types shared by the controller data port files
// assumes nothing of its surroundings
package rcdp_pkg;

   // one-hot source of the read reference clock
   typedef enum logic [3:0] {
      RCDP_SRC_TB = 4'h1,
      RCDP_SRC_TO_OSC = 4'h2,
      RCDP_SRC_OSC = 4'h4,
      RCDP_SRC_TO_TB = 4'h8
   } rcdp_src_t;

endpackage

// ---- hdl/rcdp_sync2.sv ----
// two flip-flop synchroniser for a group of pin levels
// assumes each bit is a level; no bit is read before the second stage
`timescale 1ns/1ps
`default_nettype none
`include "rcdp_regs.svh"
module rcdp_sync2 #(
   parameter int WIDTH = `RCDP_PIN_SYNC_W
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   typedef struct packed {
      logic [WIDTH-1:0] stage1;
      logic [WIDTH-1:0] stage2;
   } rcdp_sync_t;

   rcdp_sync_t s_reg;
   rcdp_sync_t s_next;

   generate
      if (WIDTH < 1) begin : g_chk
         $error("rcdp_sync2: WIDTH must be at least 1");
      end
   endgenerate

   always_comb begin
      s_next.stage1 = d;
      s_next.stage2 = s_reg.stage1;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign q = s_reg.stage2;
endmodule
`default_nettype wire

// ---- hdl/rcdp_buf2.sv ----
// small ring buffer with valid and ready on both sides
// assumes a power-of-two depth; flush drops everything held
`timescale 1ns/1ps
`default_nettype none
`include "rcdp_regs.svh"
module rcdp_buf2 #(
   parameter int WIDTH = `RCDP_BYTE_W + 1,
   parameter int DEPTH = `RCDP_BUF_DEPTH
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic flush,
   input wire logic inValid,
   input wire logic [WIDTH-1:0] inData,
   output logic inReady,
   output logic outValid,
   output logic [WIDTH-1:0] outData,
   input wire logic outReady
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wrPtr;
      logic [AW-1:0] rdPtr;
      logic [AW:0] count;
      logic ready;
   } rcdp_buf_t;

   rcdp_buf_t b_reg;
   rcdp_buf_t b_next;
   logic push;
   logic pop;

   generate
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
         $error("rcdp_buf2: DEPTH must be a power of two, at least 2");
      end
   endgenerate

   always_comb begin
      b_next = b_reg;
      push = inValid & b_reg.ready;
      pop = outReady & (b_reg.count != '0);
      if (flush) begin
         b_next.wrPtr = '0;
         b_next.rdPtr = '0;
         b_next.count = '0;
      end else begin
         if (push) begin
            b_next.mem[b_reg.wrPtr] = inData;
            b_next.wrPtr = b_reg.wrPtr + AW'(1);
         end
         if (pop) begin
            b_next.rdPtr = b_reg.rdPtr + AW'(1);
         end
         b_next.count = b_reg.count + (AW + 1)'(push) - (AW + 1)'(pop);
      end
      // registered ready keeps the source free of a combinational path
      b_next.ready = (b_next.count != (AW + 1)'(DEPTH));
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         b_reg <= '{mem: '0, wrPtr: '0, rdPtr: '0, count: '0, ready: 1'b1};
      end else begin
         b_reg <= b_next;
      end
   end

   assign inReady = b_reg.ready;
   assign outValid = (b_reg.count != '0);
   assign outData = b_reg.mem[b_reg.rdPtr];
endmodule
`default_nettype wire

// ---- hdl/rcdp_top.sv ----
// controller-side data port of a disk read channel
// assumes pins and link clocks are asynchronous to clk; decoder, encoder,
// sync field count point and mode bits are logic on clk
//
// Overview of operation
// RQ1: bus writes in on write gate, drives reads
// RQ2: nibble mode uses only low four lines
// RQ3: parity line used in byte mode only
// RQ4: even parity out on reads, in on writes
// RQ5: read gate low: reference clock from time base
// RQ6: time base until count point, then oscillator
// RQ7: source change glitch free, one pulse lost
// RQ8: half-byte clock at twice reference clock rate
// RQ9: half-byte clock also runs in byte mode
// RQ10: sync flag drops with sync byte on bus
// RQ11: sync flag held low until read gate falls
// RQ12: write data retimed to time base unless direct
// RQ13: direct select low routes toggle input through
// RQ14: capture write data on write clock rising edge
// RQ15: write gate active level set by polarity bit
// RQ16: read gate rise selects lock reference, starts lock
// RQ17: parity covers all eight bits, even total
`timescale 1ns/1ps
`default_nettype none
`include "rcdp_regs.svh"
module rcdp_top
   import rcdp_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic timebaseClk,
   input wire logic oscClk,
   input wire logic writeClk,
   input wire logic readGate,
   input wire logic writeGate,
   input wire logic writeGatePolarityBit,
   input wire logic byteMode,
   input wire logic syncFieldCountPoint,
   input wire logic directWriteSelect_n,
   input wire logic directToggleInput,
   input wire logic [`RCDP_BYTE_W-1:0] busIn,
   output logic [`RCDP_BYTE_W-1:0] busOut,
   output logic busOe_n,
   input wire logic parityIn,
   output logic parityOut,
   output logic parityOe_n,
   output logic readRefClk,
   output logic halfByteClk,
   output logic syncFoundFlag_n,
   output logic writeDataOut,
   input wire logic [`RCDP_BYTE_W-1:0] decData,
   input wire logic decSync,
   input wire logic decValid,
   output logic decReady,
   output logic [`RCDP_BYTE_W-1:0] encData,
   output logic encValid,
   output logic encParityError,
   input wire logic encBit,
   output logic lockRefSelect,
   output logic lockStart
);
   typedef struct packed {
      rcdp_src_t src;
      logic tbPrev;
      logic oscPrev;
      logic wrPrev;
      logic rgPrev;
      logic dtPrev;
      logic readRefClk;
      logic halfByteClk;
      logic [`RCDP_BYTE_W-1:0] busOut;
      logic busOe_n;
      logic parityOut;
      logic parityOe_n;
      logic syncFoundFlag_n;
      logic nibHi;
      logic [`RCDP_NIB_W-1:0] heldNib;
      logic wrHalf;
      logic [`RCDP_NIB_W-1:0] wrLowNib;
      logic [`RCDP_BYTE_W-1:0] encData;
      logic encValid;
      logic encParityError;
      logic writeDataOut;
      logic lockRefSelect;
      logic lockStart;
   } rcdp_state_t;

   localparam rcdp_state_t STATE_RST = '{
      src: RCDP_SRC_TB, busOut: `RCDP_BUS_RST, busOe_n: `RCDP_OE_OFF,
      parityOe_n: `RCDP_OE_OFF, syncFoundFlag_n: `RCDP_FLAG_IDLE,
      heldNib: `RCDP_NIB_RST, wrLowNib: `RCDP_NIB_RST,
      encData: `RCDP_BUS_RST, writeDataOut: `RCDP_WD_RST, default: 1'b0};

   rcdp_state_t s_reg;
   rcdp_state_t s_next;

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers and read buffer

   logic [`RCDP_PIN_SYNC_W-1:0] pinSync;
   logic tbS, oscS, wrS, rgS, wgS, dtS, dwS_n, parS;
   logic [`RCDP_BYTE_W-1:0] busS;

   rcdp_sync2 #(.WIDTH(`RCDP_PIN_SYNC_W)) uSync (
      .clk(clk),
      .resetn(resetn),
      .d({timebaseClk, oscClk, writeClk, readGate, writeGate,
          directToggleInput, directWriteSelect_n, parityIn, busIn}),
      .q(pinSync)
   );
   assign {tbS, oscS, wrS, rgS, wgS, dtS, dwS_n, parS, busS} = pinSync;

   logic bufValid;
   logic bufPop;
   logic [`RCDP_BYTE_W:0] bufData;

   // a stalled bus holds the decoder off rather than dropping a byte
   rcdp_buf2 #(.WIDTH(`RCDP_BYTE_W + 1), .DEPTH(`RCDP_BUF_DEPTH)) uBuf (
      .clk(clk),
      .resetn(resetn),
      .flush(s_reg.rgPrev & ~rgS),
      .inValid(decValid),
      .inData({decSync, decData}),
      .inReady(decReady),
      .outValid(bufValid),
      .outData(bufData),
      .outReady(bufPop)
   );

   ////////////////////////////////////////////////////////////////////////
   // next state

   logic tbRise, tbFall, oscRise, oscFall, wrRise, dtRise;
   logic tick, curFall, readTick, wgActive;
   logic [`RCDP_BYTE_W-1:0] popByte;

   always_comb begin
      s_next = s_reg;
      tbRise = tbS & ~s_reg.tbPrev;
      tbFall = ~tbS & s_reg.tbPrev;
      oscRise = oscS & ~s_reg.oscPrev;
      oscFall = ~oscS & s_reg.oscPrev;
      wrRise = wrS & ~s_reg.wrPrev;
      dtRise = dtS & ~s_reg.dtPrev;
      wgActive = writeGatePolarityBit ? wgS : ~wgS; // see RQ15
      popByte = bufData[`RCDP_BYTE_W-1:0];
      tick = 1'b0;
      curFall = 1'b0;
      bufPop = 1'b0;
      s_next.tbPrev = tbS;
      s_next.oscPrev = oscS;
      s_next.wrPrev = wrS;
      s_next.rgPrev = rgS;
      s_next.dtPrev = dtS;

      // reference clock divides the chosen source by two; a switch waits
      // for the clock to be low and starts on the new source's rise
      case (s_reg.src)
         RCDP_SRC_TB: begin
            tick = tbRise; // see RQ5
            curFall = tbFall;
            if (rgS && syncFieldCountPoint) begin
               s_next.src = RCDP_SRC_TO_OSC; // see RQ6
            end
         end
         RCDP_SRC_TO_OSC: begin
            if (!rgS) begin
               tick = tbRise;
               curFall = tbFall;
               s_next.src = RCDP_SRC_TB;
            end else if (s_reg.readRefClk) begin
               tick = tbRise;
               curFall = tbFall;
            end else if (oscRise) begin
               tick = 1'b1; // see RQ7
               s_next.src = RCDP_SRC_OSC;
            end
         end
         RCDP_SRC_OSC: begin
            tick = oscRise; // see RQ6
            curFall = oscFall;
            if (!rgS) begin
               s_next.src = RCDP_SRC_TO_TB;
            end
         end
         RCDP_SRC_TO_TB: begin
            if (s_reg.readRefClk) begin
               tick = oscRise;
               curFall = oscFall;
            end else if (tbRise) begin
               tick = 1'b1; // see RQ7
               s_next.src = RCDP_SRC_TB;
            end
         end
         default: begin
            s_next.src = RCDP_SRC_TB;
         end
      endcase

      if (tick) begin
         s_next.readRefClk = ~s_reg.readRefClk;
      end
      // half-byte clock rises on every source rise outside a source switch, both modes
      if (tick) begin
         s_next.halfByteClk = 1'b1; // see RQ8, RQ9
      end else if (curFall) begin
         s_next.halfByteClk = 1'b0;
      end

      // byte mode moves a byte per reference rise, nibble mode a nibble
      // per half-byte rise
      readTick = tick & rgS & (~byteMode | ~s_reg.readRefClk);
      s_next.busOe_n = ~rgS; // see RQ1
      s_next.parityOe_n = ~(rgS & byteMode); // see RQ3
      if (readTick) begin
         if (!byteMode && s_reg.nibHi) begin
            s_next.busOut = {`RCDP_NIB_RST, s_reg.heldNib}; // see RQ2
            s_next.nibHi = 1'b0;
         end else if (bufValid) begin
            bufPop = 1'b1;
            if (byteMode) begin
               s_next.busOut = popByte;
               s_next.parityOut = ^popByte; // see RQ4, RQ17
            end else begin
               s_next.busOut = {`RCDP_NIB_RST,
                                popByte[`RCDP_NIB_W-1:0]}; // see RQ2
               s_next.heldNib = popByte[`RCDP_BYTE_W-1:`RCDP_NIB_W];
               s_next.nibHi = 1'b1;
            end
            if (bufData[`RCDP_BYTE_W]) begin
               s_next.syncFoundFlag_n = 1'b0; // see RQ10
            end
         end
      end
      if (!rgS) begin
         s_next.syncFoundFlag_n = `RCDP_FLAG_IDLE; // see RQ11
         s_next.nibHi = 1'b0;
         s_next.busOut = `RCDP_BUS_RST; // see RQ2
         s_next.parityOut = 1'b0; // see RQ4
      end

      s_next.lockRefSelect = rgS; // see RQ16
      s_next.lockStart = rgS & ~s_reg.rgPrev;

      // write capture on the write clock rise while the gate is active
      s_next.encValid = 1'b0;
      if (!wgActive) begin
         s_next.wrHalf = 1'b0;
      end else if (wrRise) begin // see RQ14
         if (byteMode) begin
            s_next.encData = busS; // see RQ1
            s_next.encValid = 1'b1;
            s_next.encParityError = ^{busS, parS}; // see RQ4, RQ17
         end else if (!s_reg.wrHalf) begin
            s_next.wrLowNib = busS[`RCDP_NIB_W-1:0];
            s_next.wrHalf = 1'b1;
         end else begin
            s_next.encData = {busS[`RCDP_NIB_W-1:0], s_reg.wrLowNib};
            s_next.encValid = 1'b1;
            s_next.encParityError = 1'b0; // see RQ3
            s_next.wrHalf = 1'b0;
         end
      end

      // toggle flip-flop: retimed to the time base, or raw direct toggle
      if (!dwS_n) begin
         if (dtRise) begin
            s_next.writeDataOut = ~s_reg.writeDataOut; // see RQ13
         end
      end else if (tbRise && encBit) begin
         s_next.writeDataOut = ~s_reg.writeDataOut; // see RQ12
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_reg <= STATE_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   assign busOut = s_reg.busOut;
   assign busOe_n = s_reg.busOe_n;
   assign parityOut = s_reg.parityOut;
   assign parityOe_n = s_reg.parityOe_n;
   assign readRefClk = s_reg.readRefClk;
   assign halfByteClk = s_reg.halfByteClk;
   assign syncFoundFlag_n = s_reg.syncFoundFlag_n;
   assign writeDataOut = s_reg.writeDataOut;
   assign encData = s_reg.encData;
   assign encValid = s_reg.encValid;
   assign encParityError = s_reg.encParityError;
   assign lockRefSelect = s_reg.lockRefSelect;
   assign lockStart = s_reg.lockStart;

   ////////////////////////////////////////////////////////////////////////
   // assertions

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   sequence rgRises;
      rgS && !s_reg.rgPrev;
   endsequence
   sequence lockPulse;
      lockStart ##1 !lockStart;
   endsequence

   a_lock_start: assert property (rgRises |=> lockPulse and lockRefSelect) // see RQ16
      else $error("lock start not pulsed on read gate rise");
   a_flag_hold: assert property (!syncFoundFlag_n && rgS |=> !syncFoundFlag_n) // see RQ11
      else $error("sync flag released while read gate high");
   a_flag_release: assert property (!rgS |=> syncFoundFlag_n) // see RQ11
      else $error("sync flag not returned high after read gate");
   a_flag_drop: assert property ($fell(syncFoundFlag_n) |-> $past(bufPop && bufData[`RCDP_BYTE_W])) // see RQ10
      else $error("sync flag fell without sync byte on bus");
   a_parity_even: assert property (!parityOe_n && $past(byteMode) && byteMode |-> ^{busOut, parityOut} == 1'b0) // see RQ4
      else $error("read parity is not even");
   a_nibble_upper: assert property (!byteMode && $past(!byteMode) && !busOe_n |-> busOut[`RCDP_BYTE_W-1:`RCDP_NIB_W] == `RCDP_NIB_RST) // see RQ2
      else $error("upper lines driven in nibble mode");
   a_osc_needs_sfc: assert property ($rose(s_reg.src == RCDP_SRC_TO_OSC) |-> $past(rgS && syncFieldCountPoint)) // see RQ6
      else $error("oscillator chosen before count point");
   a_switch_clean: assert property ($rose(s_reg.src == RCDP_SRC_OSC) || $rose(s_reg.src == RCDP_SRC_TB) && $past(s_reg.src) == RCDP_SRC_TO_TB |-> $rose(readRefClk)) // see RQ7
      else $error("source switch did not start on a clean rise");
   a_wd_source: assert property ($changed(writeDataOut) |-> $past(dwS_n ? tbRise && encBit : dtRise)) // see RQ12
      else $error("write data toggled without its cause");
   a_write_capture: assert property (byteMode && wrRise && wgActive |=> encValid && encData == $past(busS)) // see RQ14
      else $error("write byte not captured on write clock rise");
endmodule
`default_nettype wire

// ---- tb/rcdp_ctl_model.sv ----
// disk controller model: gate pins, write clock and the write side of the bus
// assumes the bench calls its tasks at the falling clk edge
`timescale 1ns/1ps
`default_nettype none
module rcdp_ctl_model (
   input wire logic clk,
   output logic readGate,
   output logic writeGate,
   output logic writeClk,
   output logic [7:0] busIn,
   output logic parityIn
);
   initial begin
      readGate = 1'b0;
      writeGate = 1'b0;
      writeClk = 1'b0;
      busIn = 8'hA5;
      parityIn = 1'b0;
   end

   task automatic gates(input logic r, input logic w);
      readGate = r;
      writeGate = w;
   endtask

   // write clock stands low between bytes; released lines show the
   // inverse so stale data cannot pass for a good capture
   task automatic wr(input logic [7:0] b, input logic p);
      busIn = b;
      parityIn = p;
      repeat (4) @(negedge clk);
      writeClk = 1'b1;
      repeat (4) @(negedge clk);
      writeClk = 1'b0;
      busIn = ~b;
      parityIn = ~p;
      @(negedge clk);
   endtask
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// bench: clocks, decoder and encoder side, scoreboard and verdict
// assumes rcdp_top and the controller model rcdp_ctl_model
`timescale 1ns/1ps
`default_nettype none
module tb;
   typedef struct packed {
      logic [7:0] d;
      logic p;
      logic f;
   } rcdp_exp_t;
   logic clk, resetn, timebaseClk, oscClk, writeClk, readGate, writeGate;
   logic writeGatePolarityBit, byteMode, syncFieldCountPoint;
   logic directWriteSelect_n, directToggleInput, parityIn, parityOut;
   logic busOe_n, parityOe_n, readRefClk, halfByteClk, syncFoundFlag_n;
   logic writeDataOut, decSync, decValid, decReady, encValid;
   logic encParityError, encBit, lockRefSelect, lockStart;
   logic [7:0] busIn, busOut, decData, encData, b, c;
   logic rrQ, hbQ, wdQ, hbOn, sy;
   rcdp_exp_t rdQ[$], wrQ[$], e;
   int failures, n_checks, per, hbn, pLo, pHi, wdt, lk, st, i, j;

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      timebaseClk = 1'b0;
      #37;
      forever #100 timebaseClk = ~timebaseClk;
   end
   initial begin
      oscClk = 1'b0;
      #11;
      forever #150 oscClk = ~oscClk;
   end

   rcdp_top DUT (.clk, .resetn, .timebaseClk, .oscClk, .writeClk,
      .readGate, .writeGate, .writeGatePolarityBit, .byteMode,
      .syncFieldCountPoint, .directWriteSelect_n, .directToggleInput,
      .busIn, .busOut, .busOe_n, .parityIn, .parityOut, .parityOe_n,
      .readRefClk, .halfByteClk, .syncFoundFlag_n, .writeDataOut,
      .decData, .decSync, .decValid, .decReady, .encData, .encValid,
      .encParityError, .encBit, .lockRefSelect, .lockStart);
   rcdp_ctl_model CTL (.clk, .readGate, .writeGate, .writeClk, .busIn,
      .parityIn);

///////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic ok, input string m);
      n_checks++;
      if (ok !== 1'b1) begin
         failures++;
         $display("Error %0t: %s", $time, m);
      end
   endtask

   task automatic summarize;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic drain;
      for (i = 0; i < 3000 && rdQ.size() + wrQ.size() > 0; i++)
         @(negedge clk);
      if (rdQ.size() + wrQ.size() > 0) begin
         failures++;
         $display("Error %0t: timeout", $time);
         summarize();
      end
   endtask

   task automatic win(input int lo, input int hi, input logic h);
      pLo = lo;
      pHi = hi;
      hbOn = h;
   endtask

   // note lands after the monitor's look at the same edge, because the
   // byte taken there cannot be presented at that edge
   task automatic send(input logic [7:0] d, input logic s);
      @(negedge clk);
      decData = d;
      decSync = s;
      decValid = 1'b1;
      for (i = 0; i < 400 && decReady !== 1'b1; i++)
         @(negedge clk);
      if (i == 400) begin
         failures++;
         $display("Error %0t: ready timeout", $time);
         summarize();
      end
      if (i > 0)
         st++;
      @(posedge clk);
      #3;
      sy = sy & ~s;
      if (byteMode)
         rdQ.push_back({d, ^d, sy});
      else begin
         rdQ.push_back({4'h0, d[3:0], 1'b1, 1'b1});
         rdQ.push_back({4'h0, d[7:4], 1'b1, 1'b1});
      end
   endtask

   task automatic wdCnt(input int n);
      repeat (16) @(negedge clk);
      wdt = 0;
      repeat (64) @(negedge clk);
      chk(wdt == n, "write data");
   endtask

///////////////////////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      #2;
      per++;
      if (halfByteClk && !hbQ)
         hbn++;
      if (readRefClk && !rrQ) begin
         if (pHi > 0)
            chk(per >= pLo && per <= pHi, "rclk period");
         if (pHi > 0 && hbOn)
            chk(hbn == 2, "hclk rate");
         per = 0;
         hbn = 0;
      end
      if (busOe_n === 1'b0 && rdQ.size() > 0 &&
          (byteMode ? (readRefClk && !rrQ) : (halfByteClk && !hbQ))) begin
         e = rdQ.pop_front();
         chk(busOut === e.d, "read bus");
         chk((byteMode ? parityOut : parityOe_n) === e.p, "par");
         chk(syncFoundFlag_n === e.f, "sync flag");
      end
      if (encValid === 1'b1) begin
         chk(wrQ.size() > 0 && busOe_n === 1'b1, "stray");
         if (wrQ.size() > 0) begin
            e = wrQ.pop_front();
            chk({encData, encParityError} === {e.d, e.p}, "wr");
         end
      end
      if (writeDataOut !== wdQ)
         wdt++;
      lk += lockStart;
      rrQ = readRefClk;
      hbQ = halfByteClk;
      wdQ = writeDataOut;
   end

   initial begin
      resetn = 1'b0;
      writeGatePolarityBit = 1'b1;
      byteMode = 1'b1;
      syncFieldCountPoint = 1'b0;
      directWriteSelect_n = 1'b1;
      directToggleInput = 1'b0;
      decData = 8'h00;
      decSync = 1'b0;
      decValid = 1'b0;
      encBit = 1'b0;
      i = $urandom(15);
      repeat (2) @(negedge clk);
      chk(busOe_n === 1'b1 && syncFoundFlag_n === 1'b1, "reset");
      resetn = 1'b1;
      repeat (40) @(negedge clk);
      win(15, 17, 1'b1);
      repeat (60) @(negedge clk);
      lk = 0;
      sy = 1'b1;
      CTL.gates(1'b1, 1'b0);
      repeat (4) @(negedge clk);
      for (j = 0; j < 6; j++)
         send(8'($urandom), j == 2);
      @(negedge clk);
      decValid = 1'b0;
      drain();
      chk(st > 0, "no stall");
      chk(syncFoundFlag_n === 1'b0, "flag held");
      chk(lk == 1 && lockRefSelect === 1'b1, "lock");
      syncFieldCountPoint = 1'b1;
      win(8, 50, 1'b0);
      repeat (80) @(negedge clk);
      win(23, 25, 1'b1);
      repeat (80) @(negedge clk);
      CTL.gates(1'b0, 1'b0);
      syncFieldCountPoint = 1'b0;
      win(8, 50, 1'b0);
      repeat (80) @(negedge clk);
      chk(syncFoundFlag_n === 1'b1 && busOe_n === 1'b1, "gate low");
      chk(lockRefSelect === 1'b0, "lock ref");
      win(15, 17, 1'b1);
      byteMode = 1'b0;
      CTL.gates(1'b1, 1'b0);
      repeat (4) @(negedge clk);
      for (j = 0; j < 3; j++)
         send(8'($urandom), 1'b0);
      @(negedge clk);
      decValid = 1'b0;
      drain();
      CTL.gates(1'b0, 1'b1);
      repeat (8) @(negedge clk);
      byteMode = 1'b1;
      for (j = 0; j < 4; j++) begin
         b = 8'($urandom);
         wrQ.push_back({b, j == 1, 1'b0});
         CTL.wr(b, ^b ^ (j == 1));
      end
      CTL.gates(1'b0, 1'b0);
      CTL.wr(8'h3C, 1'b0);
      writeGatePolarityBit = 1'b0;
      wrQ.push_back({b, 1'b0, 1'b0});
      CTL.wr(b, ^b);
      CTL.gates(1'b0, 1'b1);
      CTL.wr(8'hC3, 1'b0);
      byteMode = 1'b0;
      CTL.gates(1'b0, 1'b0);
      b = 8'($urandom);
      c = 8'($urandom);
      wrQ.push_back({c[3:0], b[3:0], 1'b0, 1'b0});
      CTL.wr(b, ~^b);
      CTL.wr(c, ~^c);
      byteMode = 1'b1;
      writeGatePolarityBit = 1'b1;
      CTL.gates(1'b0, 1'b0);
      drain();
      encBit = 1'b1;
      wdCnt(8);
      encBit = 1'b0;
      wdCnt(0);
      directWriteSelect_n = 1'b0;
      encBit = 1'b1;
      repeat (16) @(negedge clk);
      wdt = 0;
      for (j = 0; j < 5; j++) begin
         directToggleInput = 1'b1;
         repeat (4) @(negedge clk);
         directToggleInput = 1'b0;
         repeat (4) @(negedge clk);
      end
      repeat (8) @(negedge clk);
      chk(wdt == 5, "direct");
      summarize();
   end
endmodule
`default_nettype wire
